/* File: hw/hsp_top.sv */
// Strap configuration, port power and upstream pull-up control of a
// seven-port hub, with an APB register slave and one interrupt line.
// Assumes all pins synchronous to core_clk (250 MHz).
//
// Contract
// - Memory strap high: default IDs, data pin is gang strap, clock unused.
// - Memory strap low: run serial memory reading IDs and gang setting.
// - Asserted overcurrent turns off power of the affected ports.
// - Ganged: all power enables switch together; any overcurrent trips all.
// - Nonganged: each power enable paired with its own overcurrent.
// - Overcurrent inputs are filtered against short spikes.
// - Clock strap low: core runs from the PLL output.
// - Clock strap high: direct input clock, PLL and oscillator powered down.
// - PLL multiplies 6 MHz reference to 48 MHz.
// - Suspend status output provided for external power-down.
// - Seven ports when self-powered, four when bus-powered.
// - Pull-up enable inactive 15 ms after reset or power strap change.
// - Then pull-up driven high until next reset or strap change.
`timescale 1ns/100ps
`include "hsp_map.svh"
module hsp_top
  import hsp_pkg::*;
#(
  parameter int unsigned  PULLUP_DELAY_CYC = `HSP_PULLUP_CYC,
  // Default identifiers: values are arbitrary
  parameter logic [15:0]  DEFAULT_VID      = 16'h1234,
  parameter logic [15:0]  DEFAULT_PID      = 16'h5678
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_memory_strap,
  input  wire logic        clock_mode_strap,
  input  wire logic        power_source_strap,
  input  wire logic        hub_suspend,
  output logic             serial_mem_clock,
  output logic             serial_mem_clock_oe_n,
  output logic             serial_mem_select,
  input  wire logic        serial_mem_data_in,
  output logic             serial_mem_data_out,
  output logic             serial_mem_data_oe_n,
  input  wire logic [6:0]  port_overcurrent_in_n,
  output logic [6:0]       port_power_enable,
  output logic             core_clk_sel_pll,
  output logic             pll_powerdown,
  output logic             osc_powerdown,
  output logic [3:0]       pll_mult,
  output logic             suspend_status_out,
  output logic             upstream_pullup_enable,
  output logic             upstream_pullup_oe_n,
  output logic             irq
);

  // ******************************************************************
  // Reset release
  // ******************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_n_reg;

  // ******************************************************************
  // Strap capture
  // ******************************************************************
  // Memory and gang straps are static: caught once after release
  logic taken_reg;
  logic ext_strap_reg;
  logic gang_strap_reg;
  logic pwr_strap_reg;
  logic clk_strap_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_reg      <= 1'b0;
      ext_strap_reg  <= 1'b1;
      gang_strap_reg <= 1'b0;
      pwr_strap_reg  <= 1'b0;
      clk_strap_reg  <= 1'b0;
    end else begin
      taken_reg     <= 1'b1;
      pwr_strap_reg <= power_source_strap;
      clk_strap_reg <= clock_mode_strap;
      if (!taken_reg) begin
        ext_strap_reg  <= ext_memory_strap;
        gang_strap_reg <= serial_mem_data_in;
      end
    end
  end
  wire logic strap_change = taken_reg && (pwr_strap_reg != power_source_strap);
  wire logic self_powered = pwr_strap_reg;

  // ******************************************************************
  // Clock source selection
  // ******************************************************************
  assign core_clk_sel_pll = ~clk_strap_reg;
  assign pll_powerdown    = clk_strap_reg;
  assign osc_powerdown    = clk_strap_reg;
  assign pll_mult         = `HSP_PLL_MULT;

  // ******************************************************************
  // Serial memory reader
  // ******************************************************************
  // Words 0..2 hold vendor id, product id and gang setting
  localparam logic [7:0] HALF_MAX = 8'(`HSP_SMEM_HALF_CYC - 1);
  hsp_smem_state_t smem_state_reg;
  hsp_smem_state_t smem_state_next;
  logic [7:0]  div_reg;
  logic        sclk_reg;
  logic [4:0]  bit_reg;
  logic [1:0]  word_reg;
  logic [8:0]  cmd_reg;
  logic [15:0] shift_reg;
  logic [15:0] vid_mem_reg;
  logic [15:0] pid_mem_reg;
  logic        gang_mem_reg;
  wire logic tick      = div_reg == HALF_MAX;
  wire logic in_xfer   = smem_state_reg == SMEM_XFER;
  wire logic rise      = in_xfer && tick && !sclk_reg;
  wire logic fall      = in_xfer && tick && sclk_reg;
  wire logic word_end  = fall && (bit_reg == `HSP_SMEM_LAST_BIT);
  wire logic sending   = in_xfer && (bit_reg < `HSP_SMEM_CMD_BITS);
  wire logic smem_done = smem_state_reg == SMEM_DONE;
  wire logic [8:0] cmd_init = {`HSP_SMEM_READ_OP, 4'h0, word_reg};
  always_comb begin
    smem_state_next = smem_state_reg;
    unique case (smem_state_reg)
      SMEM_IDLE: begin
        if (taken_reg) begin
          smem_state_next = ext_strap_reg ? SMEM_DONE : SMEM_XFER;
        end
      end
      SMEM_XFER: begin
        if (word_end) begin
          smem_state_next = SMEM_GAP;
        end
      end
      SMEM_GAP: begin
        if (tick) begin
          smem_state_next = (word_reg == `HSP_SMEM_WORDS) ? SMEM_DONE : SMEM_XFER;
        end
      end
      SMEM_DONE: begin
        smem_state_next = SMEM_DONE;
      end
      default: begin
        smem_state_next = SMEM_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      smem_state_reg <= SMEM_IDLE;
      div_reg        <= 8'h00;
      sclk_reg       <= 1'b0;
    end else begin
      smem_state_reg <= smem_state_next;
      div_reg        <= tick ? 8'h00 : div_reg + 8'h01;
      sclk_reg       <= in_xfer && (tick ? !sclk_reg : sclk_reg);
    end
  end
  // Data changes on falling clock, sampled on rising clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_reg   <= 5'h00;
      word_reg  <= 2'h0;
      cmd_reg   <= 9'h000;
      shift_reg <= 16'h0000;
    end else if (smem_state_reg != SMEM_XFER) begin
      bit_reg <= 5'h00;
      cmd_reg <= cmd_init;
    end else begin
      if (rise && !sending) begin
        shift_reg <= {shift_reg[14:0], serial_mem_data_in};
      end
      if (fall) begin
        bit_reg <= bit_reg + 5'h01;
        cmd_reg <= {cmd_reg[7:0], 1'b0};
      end
      if (word_end) begin
        word_reg <= word_reg + 2'h1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vid_mem_reg  <= 16'h0000;
      pid_mem_reg  <= 16'h0000;
      gang_mem_reg <= 1'b0;
    end else if (word_end) begin
      unique case (word_reg)
        2'h0: vid_mem_reg <= shift_reg;
        2'h1: pid_mem_reg <= shift_reg;
        2'h2: gang_mem_reg <= shift_reg[0];
        default: ;
      endcase
    end
  end
  // Clock and data pins float when the interface is disabled so the memory can be shared; select is driven low
  assign serial_mem_clock      = sclk_reg;
  assign serial_mem_clock_oe_n = ext_strap_reg || !in_xfer;
  assign serial_mem_select     = in_xfer;
  assign serial_mem_data_out   = cmd_reg[8];
  assign serial_mem_data_oe_n  = !sending;
  wire logic        ganged  = ext_strap_reg ? gang_strap_reg : gang_mem_reg;
  wire logic [15:0] eff_vid = ext_strap_reg ? DEFAULT_VID : vid_mem_reg;
  wire logic [15:0] eff_pid = ext_strap_reg ? DEFAULT_PID : pid_mem_reg;

  // ******************************************************************
  // Overcurrent filter and port power
  // ******************************************************************
  hsp_oc_if oc_bus ();
  assign oc_bus.raw_n = port_overcurrent_in_n;
  hsp_oc_filter u_oc_filter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .oc       (oc_bus.filter)
  );
  logic [6:0] pwr_req_reg;
  logic [6:0] pwr_en_reg;
  logic [6:0] oc_prev_reg;
  wire logic [6:0] port_mask = self_powered ? `HSP_SELF_PORTS_MASK
                                            : `HSP_BUS_PORTS_MASK;
  wire logic [6:0] oc_live   = oc_bus.filt & port_mask;
  wire logic       gang_oc   = |oc_live;
  wire logic       gang_on   = pwr_req_reg[0] && !gang_oc;
  wire logic [6:0] pwr_gang  = {7{gang_on}} & port_mask;
  wire logic [6:0] pwr_port  = pwr_req_reg & ~oc_live & port_mask;
  wire logic [6:0] pwr_next  = !smem_done ? 7'h00
                             : (ganged ? pwr_gang : pwr_port);
  wire logic       oc_event  = |(oc_live & ~oc_prev_reg);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_en_reg  <= 7'h00;
      oc_prev_reg <= 7'h00;
    end else begin
      pwr_en_reg  <= pwr_next;
      oc_prev_reg <= oc_live;
    end
  end
  assign port_power_enable = pwr_en_reg;

  // ******************************************************************
  // Suspend status
  // ******************************************************************
  logic susp_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      susp_reg <= 1'b0;
    end else begin
      susp_reg <= hub_suspend;
    end
  end
  // Outside logic stops its oscillator while this is high
  assign suspend_status_out = susp_reg;
  wire logic susp_event = hub_suspend && !susp_reg;
  // ******************************************************************
  // Upstream pull-up delay
  // ******************************************************************
  // Bus reset of the hub core does not reach this counter
  logic [31:0] pu_cnt_reg;
  logic        pu_on_reg;
  wire logic   pu_expire = !pu_on_reg && (pu_cnt_reg == PULLUP_DELAY_CYC - 1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_reg <= 32'h0000_0000;
      pu_on_reg  <= 1'b0;
    end else if (strap_change) begin
      pu_cnt_reg <= 32'h0000_0000;
      pu_on_reg  <= 1'b0;
    end else if (pu_expire) begin
      pu_on_reg <= 1'b1;
    end else if (!pu_on_reg) begin
      pu_cnt_reg <= pu_cnt_reg + 32'h0000_0001;
    end
  end
  assign upstream_pullup_enable = pu_on_reg;
  assign upstream_pullup_oe_n   = !pu_on_reg;

  // ******************************************************************
  // APB slave
  // ******************************************************************
  logic [`HSP_IRQ_W-1:0] irq_stat_reg;
  logic [`HSP_IRQ_W-1:0] irq_en_reg;
  logic [31:0]           rdata_reg;
  logic                  err_reg;
  wire logic setup  = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic hit_pctl = paddr == `HSP_PWR_CTRL_OFS;
  wire logic hit_cfg  = paddr == `HSP_CFG_STAT_OFS;
  wire logic hit_ist  = paddr == `HSP_IRQ_STAT_OFS;
  wire logic hit_icl  = paddr == `HSP_IRQ_CLR_OFS;
  wire logic hit_ien  = paddr == `HSP_IRQ_EN_OFS;
  wire logic hit_vid  = paddr == `HSP_VID_OFS;
  wire logic hit_pid  = paddr == `HSP_PID_OFS;
  wire logic hit_pst  = paddr == `HSP_PWR_STAT_OFS;
  wire logic mapped   = hit_pctl | hit_cfg | hit_ist | hit_icl
                      | hit_ien | hit_vid | hit_pid | hit_pst;
  wire logic [6:0] cfg_bits = {susp_reg, smem_done, pu_on_reg, clk_strap_reg,
                               self_powered, ganged, ext_strap_reg};
  wire logic [31:0] rd_mux =
      hit_pctl ? {25'h0, pwr_req_reg} :
      hit_cfg  ? {25'h0, cfg_bits} :
      hit_ist  ? {27'h0, irq_stat_reg} :
      hit_ien  ? {27'h0, irq_en_reg} :
      hit_vid  ? {16'h0, eff_vid} :
      hit_pid  ? {16'h0, eff_pid} :
      hit_pst  ? {9'h0, oc_live, 9'h0, pwr_en_reg} : 32'h0000_0000;
  // Answer registered in setup so access phase needs no wait state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      err_reg   <= !mapped || (pwrite && (hit_cfg || hit_ist || hit_vid
                                          || hit_pid || hit_pst));
    end
  end
  assign pready  = psel && penable;
  assign prdata  = rdata_reg;
  assign pslverr = psel && penable && err_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_req_reg <= `HSP_PWR_CTRL_RST;
      irq_en_reg  <= `HSP_IRQ_EN_RST;
    end else if (wr_acc) begin
      if (hit_pctl) begin
        pwr_req_reg <= pwdata[6:0];
      end
      if (hit_ien) begin
        irq_en_reg <= pwdata[`HSP_IRQ_W-1:0];
      end
    end
  end

  // ******************************************************************
  // Interrupt status
  // ******************************************************************
  // A new event beats a clear written in the same cycle
  wire logic [`HSP_IRQ_W-1:0] irq_set = {smem_state_next == SMEM_DONE && !smem_done,
                                         susp_event, strap_change, pu_expire, oc_event};
  wire logic [`HSP_IRQ_W-1:0] irq_clr = (wr_acc && hit_icl) ? pwdata[`HSP_IRQ_W-1:0] : 5'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 5'h00;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg);

endmodule

/* File: hw/hsp_map.svh */
// Offsets, field positions, reset values and timing counts of the hub
// strap/port-power block. Assumes a 250 MHz core clock.
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH

// ********************************************************************
// Clock and timing
// ********************************************************************
`define HSP_CLK_MHZ        250
`define HSP_CLK_KHZ        250000
`define HSP_PULLUP_MS      15
`define HSP_PULLUP_CYC     (`HSP_PULLUP_MS * `HSP_CLK_KHZ)
`define HSP_OC_FILT_NS     4000
`define HSP_OC_FILT_CYC    ((`HSP_OC_FILT_NS * `HSP_CLK_MHZ + 999) / 1000)
`define HSP_SMEM_HALF_NS   500
`define HSP_SMEM_HALF_CYC  ((`HSP_SMEM_HALF_NS * `HSP_CLK_MHZ + 999) / 1000)
`define HSP_PLL_MULT       4'h8

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define HSP_PWR_CTRL_OFS   12'h000
`define HSP_CFG_STAT_OFS   12'h004
`define HSP_IRQ_STAT_OFS   12'h008
`define HSP_IRQ_CLR_OFS    12'h00C
`define HSP_IRQ_EN_OFS     12'h010
`define HSP_VID_OFS        12'h014
`define HSP_PID_OFS        12'h018
`define HSP_PWR_STAT_OFS   12'h01C

// ********************************************************************
// Fields and reset values
// ********************************************************************
`define HSP_CFG_EXT_MEMORY_STRAP_BIT 0
`define HSP_CFG_GANG_BIT   1
`define HSP_CFG_SELF_BIT   2
`define HSP_CFG_CLKDIR_BIT 3
`define HSP_CFG_PULLUP_BIT 4
`define HSP_CFG_READY_BIT  5
`define HSP_CFG_SUSP_BIT   6
`define HSP_IRQ_OC_BIT     0
`define HSP_IRQ_PULLUP_BIT 1
`define HSP_IRQ_STRAP_BIT  2
`define HSP_IRQ_SUSP_BIT   3
`define HSP_IRQ_SMEM_BIT   4
`define HSP_IRQ_W          5
`define HSP_PWR_CTRL_RST   7'h00
`define HSP_IRQ_EN_RST     5'h00
`define HSP_SMEM_WORDS     2'h3
`define HSP_SMEM_CMD_BITS  5'h09
`define HSP_SMEM_LAST_BIT  5'h19
`define HSP_SMEM_READ_OP   3'h6
`define HSP_BUS_PORTS_MASK 7'h0F
`define HSP_SELF_PORTS_MASK 7'h7F

`endif

/* File: hw/hsp_pkg.sv */
// Types shared by the hub strap/port-power block.
// Assumes nothing beyond a SystemVerilog compiler.
package hsp_pkg;
  localparam int HSP_PORTS = 7;
  typedef logic [HSP_PORTS-1:0] hsp_port_vec_t;
  typedef enum logic [2:0] {
    SMEM_IDLE,
    SMEM_XFER,
    SMEM_GAP,
    SMEM_DONE
  } hsp_smem_state_t;
endpackage

/* File: hw/hsp_oc_if.sv */
// Carrier between the top and the overcurrent filter.
// Assumes both ends share core_clk.
`timescale 1ns/100ps
interface hsp_oc_if;
  import hsp_pkg::*;
  hsp_port_vec_t raw_n;
  hsp_port_vec_t filt;
  modport top    (output raw_n, input filt);
  modport filter (input raw_n, output filt);
endinterface

/* File: hw/hsp_oc_filter.sv */
// Glitch filter for the active-low overcurrent inputs.
// Assumes inputs already synchronous to core_clk.
`timescale 1ns/100ps
`include "hsp_map.svh"
module hsp_oc_filter
  import hsp_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  hsp_oc_if.filter  oc
);
  localparam logic [11:0] FILT_MAX = 12'(`HSP_OC_FILT_CYC - 1);

  // ******************************************************************
  // Per-port stability counters
  // ******************************************************************
  // Level must hold FILT_MAX+1 cycles before it is believed either way
  for (genvar i = 0; i < HSP_PORTS; i++) begin : g_port
    logic [11:0] cnt_reg;
    logic        filt_reg;
    wire logic   raw_oc = ~oc.raw_n[i];
    wire logic   differs = raw_oc != filt_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_reg  <= 12'h000;
        filt_reg <= 1'b0;
      end else if (!differs) begin
        cnt_reg <= 12'h000;
      end else if (cnt_reg == FILT_MAX) begin
        cnt_reg  <= 12'h000;
        filt_reg <= raw_oc;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
    assign oc.filt[i] = filt_reg;
  end
endmodule

/* File: tb/hsp_top_props.sv */
// Port-level checker for hsp_top.
// Assumes one core_clk domain; bound to every hsp_top instance.
`timescale 1ns/100ps
module hsp_top_props #(
  parameter int unsigned PULLUP_DELAY_CYC = 50
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       ext_memory_strap,
  input wire logic       clock_mode_strap,
  input wire logic       power_source_strap,
  input wire logic       hub_suspend,
  input wire logic       serial_mem_clock_oe_n,
  input wire logic       serial_mem_select,
  input wire logic       serial_mem_data_oe_n,
  input wire logic [6:0] port_power_enable,
  input wire logic       core_clk_sel_pll,
  input wire logic       pll_powerdown,
  input wire logic       osc_powerdown,
  input wire logic [3:0] pll_mult,
  input wire logic       suspend_status_out,
  input wire logic       upstream_pullup_enable,
  input wire logic       upstream_pullup_oe_n
);
  // ****
  // Helper logic
  // ****
  logic [2:0]  sync_reg;
  logic        strap_reg;
  logic        rst_ok;
  int unsigned pu_cnt;
  // One stage slower than the design's synchroniser, so no edge is judged early
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], 1'b1};
    end
  end
  assign rst_ok = sync_reg[2];
  always_ff @(posedge core_clk) begin
    strap_reg <= power_source_strap;
    if (!rst_ok || strap_reg != power_source_strap) begin
      pu_cnt <= 0;
    end else if (pu_cnt < PULLUP_DELAY_CYC + 8) begin
      pu_cnt <= pu_cnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_ok);
  sequence s_bus_mode;
    !power_source_strap [*3];
  endsequence
  // ****
  // Assertions
  // ****
  chk_clk_direct: assert property (
    clock_mode_strap |=> !core_clk_sel_pll && pll_powerdown && osc_powerdown)
    else $error("direct clock mode not applied");
  chk_clk_pll: assert property (
    !clock_mode_strap |=> core_clk_sel_pll && !pll_powerdown && !osc_powerdown)
    else $error("pll clock mode not applied");
  chk_pll_mult: assert property (pll_mult == 4'h8)
    else $error("pll multiplier wrong");
  chk_susp_follow: assert property (
    1'b1 |=> suspend_status_out == $past(hub_suspend))
    else $error("suspend status does not follow");
  chk_bus_ports: assert property (
    s_bus_mode |-> port_power_enable[6:4] == 3'h0)
    else $error("upper ports powered in bus mode");
  chk_pu_wait: assert property (
    pu_cnt + 4 < PULLUP_DELAY_CYC |-> !upstream_pullup_enable && upstream_pullup_oe_n)
    else $error("pull-up enabled too early");
  chk_pu_on: assert property (
    pu_cnt > PULLUP_DELAY_CYC + 4 |-> upstream_pullup_enable && !upstream_pullup_oe_n)
    else $error("pull-up not driven after delay");
  chk_mem_off: assert property (
    ext_memory_strap |-> serial_mem_clock_oe_n && serial_mem_data_oe_n && !serial_mem_select)
    else $error("serial memory pins active");
  chk_mem_drive: assert property (
    !serial_mem_data_oe_n |-> serial_mem_select && !ext_memory_strap)
    else $error("serial data driven outside a word");
endmodule
bind hsp_top hsp_top_props #(.PULLUP_DELAY_CYC(PULLUP_DELAY_CYC)) u_props (.*);

/* File: tb/hsp_smem_model.sv */
// Serial identity memory at the far side of the hub.
// Assumes command bits sampled on rising sclk, data launched on falling.
`timescale 1ns/100ps
module hsp_smem_model #(
  parameter logic [15:0] VID_WORD  = 16'hA5C3,
  parameter logic [15:0] PID_WORD  = 16'h3C5A,
  parameter logic [15:0] GANG_WORD = 16'h0001
) (
  input  wire logic sclk,
  input  wire logic cs,
  input  wire logic din,
  output logic      dout,
  output logic      dout_en
);
  logic [4:0]  nbit;
  logic [7:0]  cmd;
  logic [16:0] data;
  logic        loaded;
  logic [4:0]  oidx;
  initial begin
    nbit = 5'h00;
    loaded = 1'b0;
    dout_en = 1'b0;
    oidx = 5'h10;
  end
  always @(posedge sclk or negedge cs) begin
    if (!cs) begin
      nbit <= 5'h00;
      loaded <= 1'b0;
    end else if (nbit < 5'h09) begin
      cmd <= {cmd[6:0], din};
      nbit <= nbit + 5'h01;
      // Only a read opcode gets an answer
      if (nbit == 5'h08 && cmd[7:5] == 3'h6) begin
        loaded <= 1'b1;
        data <= {1'b0, ({cmd[0], din} == 2'h0) ? VID_WORD :
                 ({cmd[0], din} == 2'h1) ? PID_WORD : GANG_WORD};
      end
    end
  end
  // Released line falls to the pull-down, not the last bit
  always @(negedge sclk or negedge cs) begin
    if (!cs) begin
      dout_en <= 1'b0;
      oidx <= 5'h10;
    end else if (loaded) begin
      dout <= data[oidx];
      dout_en <= 1'b1;
      oidx <= oidx - 5'h01;
    end
  end
endmodule

/* File: tb/hsp_top_test.sv */
// Self-checking bench for hsp_top with a serial memory model.
// Assumes a 250 MHz core clock and the register map header.
`timescale 1ns/100ps
`include "hsp_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hsp_top_test;
  localparam int OCF = 1000;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        err, gang_pin, mdl_bit, mdl_en;
  logic        ext_memory_strap, clock_mode_strap, power_source_strap, hub_suspend;
  logic        serial_mem_clock, serial_mem_clock_oe_n, serial_mem_select;
  logic        serial_mem_data_out, serial_mem_data_oe_n;
  logic [6:0]  port_overcurrent_in_n, port_power_enable;
  logic        core_clk_sel_pll, pll_powerdown, osc_powerdown;
  logic [3:0]  pll_mult;
  logic        suspend_status_out, upstream_pullup_enable, upstream_pullup_oe_n;
  int          n_mismatch, total_checks, cycles;
  // Both serial pins have pull-downs when released
  wire sclk_w = !serial_mem_clock_oe_n & serial_mem_clock;
  wire serial_mem_data_in = ext_memory_strap ? gang_pin :
    (!serial_mem_data_oe_n ? serial_mem_data_out : (mdl_en & mdl_bit));
  // Identity defaults: values are arbitrary
  hsp_top #(.PULLUP_DELAY_CYC(50), .DEFAULT_VID(16'h0F1E), .DEFAULT_PID(16'h2D3C)) u_dut (.*);
  hsp_smem_model u_mem (.sclk(sclk_w), .cs(serial_mem_select), .din(serial_mem_data_in),
    .dout(mdl_bit), .dout_en(mdl_en));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic probe();
    tick(2);
    @(negedge core_clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No cycle count assumed: the global timeout ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic wait_cfg(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `HSP_CFG_STAT_OFS, 32'h0);
      n++;
    end while (rdat[b] !== 1'b1 && n < 9000);
    `CHK(rdat[b], 1'b1)
  endtask
  task automatic do_reset(input logic ext);
    resetn <= 1'b0;
    ext_memory_strap <= ext;
    tick(6);
    resetn <= 1'b1;
    tick(3);
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gang_pin, clock_mode_strap, hub_suspend, cycles} = '0;
    {n_mismatch, total_checks} = '0;
    ext_memory_strap = 1'b1;
    power_source_strap = 1'b1;
    port_overcurrent_in_n = 7'h7F;
    @(posedge core_clk);
    do_reset(1'b1);
    rd(`HSP_PWR_CTRL_OFS, 32'h0);
    rd(`HSP_IRQ_EN_OFS, 32'h0);
    rd(`HSP_VID_OFS, 32'h0F1E);
    rd(`HSP_PID_OFS, 32'h2D3C);
    wait_cfg(4);
    rd(`HSP_CFG_STAT_OFS, 32'h35);
    apb(1'b1, `HSP_PWR_CTRL_OFS, 32'h7F);
    port_overcurrent_in_n <= 7'h7B;
    tick(OCF / 2);
    port_overcurrent_in_n <= 7'h7F;
    rd(`HSP_PWR_STAT_OFS, 32'h7F);
    apb(1'b1, `HSP_IRQ_EN_OFS, 32'h1);
    port_overcurrent_in_n <= 7'h7B;
    tick(OCF + 20);
    rd(`HSP_PWR_STAT_OFS, 32'h0004_007B);
    probe();
    `CHK(irq, 1'b1)
    apb(1'b1, `HSP_IRQ_EN_OFS, 32'h0);
    probe();
    `CHK(irq, 1'b0)
    apb(1'b1, `HSP_IRQ_EN_OFS, 32'h1);
    apb(1'b1, `HSP_IRQ_CLR_OFS, 32'h1);
    probe();
    `CHK(irq, 1'b0)
    tick(1);
    port_overcurrent_in_n <= 7'h7F;
    tick(OCF + 20);
    rd(`HSP_PWR_STAT_OFS, 32'h7F);
    rd(`HSP_IRQ_CLR_OFS, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `HSP_CFG_STAT_OFS, 32'hFF);
    `CHK(err, 1'b1)
    clock_mode_strap <= 1'b1;
    hub_suspend <= 1'b1;
    probe();
    `CHK({core_clk_sel_pll, pll_powerdown, osc_powerdown, suspend_status_out}, 4'h7)
    tick(1);
    clock_mode_strap <= 1'b0;
    hub_suspend <= 1'b0;
    probe();
    `CHK({core_clk_sel_pll, pll_powerdown, osc_powerdown, pll_mult}, 7'h48)
    tick(1);
    power_source_strap <= 1'b0;
    probe();
    `CHK({upstream_pullup_enable, upstream_pullup_oe_n}, 2'h1)
    wait_cfg(4);
    probe();
    `CHK({upstream_pullup_enable, upstream_pullup_oe_n}, 2'h2)
    rd(`HSP_PWR_STAT_OFS, 32'h0F);
    rd(`HSP_IRQ_STAT_OFS, 32'h1E);
    power_source_strap <= 1'b1;
    tick(1);
    do_reset(1'b0);
    wait_cfg(5);
    rd(`HSP_VID_OFS, 32'hA5C3);
    rd(`HSP_PID_OFS, 32'h3C5A);
    rd(`HSP_IRQ_STAT_OFS, 32'h12);
    rd(`HSP_CFG_STAT_OFS, 32'h36);
    apb(1'b1, `HSP_PWR_CTRL_OFS, 32'h1);
    tick(3);
    rd(`HSP_PWR_STAT_OFS, 32'h7F);
    port_overcurrent_in_n <= 7'h5F;
    tick(OCF + 20);
    rd(`HSP_PWR_STAT_OFS, 32'h0020_0000);
    test_done();
  end
endmodule
